// ===== verilog/ctam_monitor.sv
// Cabinet thermometer alarm monitor: menu, logs, calibration, alarm and APB slave.
// Assumes raw pin inputs (buttons, switches, sensor word) and an APB master on i_clk.
//
// Contract
// - Set steps upper, lower, peak, trough, calibration.
// - Alarm limits span minus forty to 199.
// - Keep peak temperature; reset press clears it.
// - Keep trough temperature; reset press clears it.
// - Add calibration offset, minus thirty to thirty.
// - Arrows step value by one; set commits.
// - Fifteen idle seconds abandon menu, discard edits.
// - Save flashes display once; otherwise nothing stored (here an APB write to REG_CAL also stores calibration).
// - Switch one selects zero or 45 minute delay.
// - Alarm asserts beyond limit, now or delayed.
// - Switch two selects automatic or manual clearing.
// - Automatic mode clears once temperature returns.
// - Manual mode holds alarm until reset press.
// - Switches three, four pick silencing time.
// - Both switches on disable all alarms.
// - Reset press silences audible alarm.
// - Active alarm flashes the temperature display.
// - Low battery lights three dots.
// - Mains lost: reset shows temperature, sounds.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

module ctam_monitor
  import ctam_pkg::*;
#(
  parameter int P_SEC_CYCLES = SEC_CYCLES
)
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Operator pins
  input  wire ctam_btn_s   i_btn,
  input  wire ctam_cfg_s   i_dip,
  input  wire logic        i_batt_low,
  input  wire logic        i_mains_lost,
  input  wire ctam_temp_t  i_sensor,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Display and alarm outputs
  output ctam_temp_t       o_disp_value,
  output logic             o_disp_lit,
  output logic [2:0]       o_menu_item,
  output logic [2:0]       o_batt_dots,
  output logic             o_alarm_relay,
  output logic             o_audible
);

  // ----------------------------------------------------------------
  // Pin synchronisers and button edges
  // ----------------------------------------------------------------
  logic [19:0] pin_m_q;
  logic [19:0] pin_s_q;
  logic [3:0]  btn_p_q;

  always_ff @(posedge i_clk)
  begin
    pin_m_q <= {i_btn, i_dip, i_batt_low, i_mains_lost, i_sensor};
    pin_s_q <= pin_m_q;
    btn_p_q <= pin_s_q[19:16];
  end

  ctam_btn_s  press;
  ctam_cfg_s  dip_s;
  logic       batt_s;
  logic       mains_s;
  ctam_temp_t sens_s;

  assign press   = ctam_btn_s'(pin_s_q[19:16] & ~btn_p_q);
  assign dip_s   = ctam_cfg_s'(pin_s_q[15:12]);
  assign batt_s  = pin_s_q[11];
  assign mains_s = pin_s_q[10];
  assign sens_s  = pin_s_q[9:0];

  // ----------------------------------------------------------------
  // Switch capture and one-second enable
  // ----------------------------------------------------------------
  logic [1:0]  cap_q;
  ctam_cfg_s   cfg_q;
  logic [24:0] div_q;
  logic        tick_q;
  logic        cfg_ok;

  assign cfg_ok = (cap_q == CFG_CAP_DONE);

  // Capture continues until the synchroniser holds real pin levels.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cap_q <= 2'h0;
      cfg_q <= '0;
    end
    else if (!cfg_ok)
    begin
      cap_q <= cap_q + 2'h1;
      cfg_q <= dip_s;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || div_q == 25'(P_SEC_CYCLES - 1))
      div_q <= 25'h0;
    else
      div_q <= div_q + 25'h1;
    tick_q <= !i_rst && (div_q == 25'(P_SEC_CYCLES - 1));
  end

  // ----------------------------------------------------------------
  // Calibrated temperature
  // ----------------------------------------------------------------
  ctam_temp_t upper_q;
  ctam_temp_t lower_q;
  ctam_temp_t cal_q;
  ctam_temp_t temp_w;

  assign temp_w = sens_s + cal_q;

  // ----------------------------------------------------------------
  // Menu state machine
  // ----------------------------------------------------------------
  ctam_menu_e menu_q;
  ctam_menu_e menu_d;
  ctam_temp_t upper_e_q;
  ctam_temp_t lower_e_q;
  ctam_temp_t cal_e_q;
  logic [11:0] idle_q;
  logic        timeout;
  logic        commit;

  function automatic ctam_temp_t step_val(ctam_temp_t v, ctam_btn_s b, ctam_temp_t vmin, ctam_temp_t vmax);
    step_val = v;
    if (b.up && v < vmax)
      step_val = v + 10'sh001;
    else if (b.down && v > vmin)
      step_val = v - 10'sh001;
  endfunction

  assign timeout = (menu_q != MENU_IDLE) && (idle_q > MENU_TO_TK);
  assign commit  = (menu_q == MENU_CAL) && press.set && !timeout;

  always_comb
  begin
    menu_d = menu_q;
    case (menu_q)
      MENU_IDLE:   if (press.set) menu_d = MENU_UPPER;
      MENU_UPPER:  if (press.set) menu_d = MENU_LOWER;
      MENU_LOWER:  if (press.set) menu_d = MENU_PEAK;
      MENU_PEAK:   if (press.set) menu_d = MENU_TROUGH;
      MENU_TROUGH: if (press.set) menu_d = MENU_CAL;
      MENU_CAL:    if (press.set) menu_d = MENU_IDLE;
      default:     menu_d = MENU_IDLE;
    endcase
    if (timeout)
      menu_d = MENU_IDLE;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      menu_q <= MENU_IDLE;
    else
      menu_q <= menu_d;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || menu_q == MENU_IDLE || (|press))
      idle_q <= 12'h000;
    else if (tick_q && idle_q <= MENU_TO_TK)
      idle_q <= idle_q + 12'h001;
  end

  // Edits live in shadows until the last set press of the sequence.
  always_ff @(posedge i_clk)
  begin
    if (menu_q == MENU_IDLE)
    begin
      upper_e_q <= upper_q;
      lower_e_q <= lower_q;
      cal_e_q   <= cal_q;
    end
    else
    begin
      if (menu_q == MENU_UPPER)
        upper_e_q <= step_val(upper_e_q, press, LIMIT_MIN, LIMIT_MAX);
      if (menu_q == MENU_LOWER)
        lower_e_q <= step_val(lower_e_q, press, LIMIT_MIN, LIMIT_MAX);
      if (menu_q == MENU_CAL)
        cal_e_q <= step_val(cal_e_q, press, CAL_MIN, CAL_MAX);
    end
  end

  // ----------------------------------------------------------------
  // Stored settings
  // ----------------------------------------------------------------
  logic        apb_acc;
  logic        apb_done;
  logic        cal_wr;
  ctam_temp_t  wr_val;

  assign apb_acc  = i_psel && i_penable;
  assign apb_done = apb_acc && o_pready;
  assign wr_val   = i_pwdata[9:0];
  assign cal_wr   = apb_done && i_pwrite && (i_paddr == REG_CAL) && wr_val >= CAL_MIN && wr_val <= CAL_MAX;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      upper_q <= UPPER_RESET;
      lower_q <= LOWER_RESET;
      cal_q   <= CAL_RESET;
    end
    else if (commit)
    begin
      upper_q <= upper_e_q;
      lower_q <= lower_e_q;
      cal_q   <= cal_e_q;
    end
    else if (cal_wr)
      cal_q <= wr_val;
  end

  // ----------------------------------------------------------------
  // Peak and trough logs
  // ----------------------------------------------------------------
  ctam_temp_t peak_q;
  ctam_temp_t trough_q;
  logic       log_ok_q;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      log_ok_q <= 1'b0;
    else if (cfg_ok)
      log_ok_q <= 1'b1;
    if (cfg_ok && (!log_ok_q || press.rst))
    begin
      peak_q   <= temp_w;
      trough_q <= temp_w;
    end
    else
    begin
      if (temp_w > peak_q)
        peak_q <= temp_w;
      if (temp_w < trough_q)
        trough_q <= temp_w;
    end
  end

  // ----------------------------------------------------------------
  // Alarm, delay and silencing
  // ----------------------------------------------------------------
  logic        out_lim;
  logic        no_alarm;
  logic        trip;
  logic        clr;
  logic        alarm_q;
  logic [11:0] dly_q;
  logic [11:0] sil_q;
  logic [11:0] sil_lim;
  logic        sil_en;
  logic        silenced_q;
  logic        beep_q;

  assign out_lim  = cfg_ok && (temp_w > upper_q || temp_w < lower_q);
  assign no_alarm = cfg_q.sw3 && cfg_q.sw4;
  assign trip     = out_lim && !no_alarm && (!cfg_q.delay_en || dly_q >= ALARM_DELAY_TK);
  assign clr      = no_alarm || (cfg_q.manual_rst ? press.rst : !out_lim);
  assign sil_en   = cfg_q.sw3 ^ cfg_q.sw4;
  assign sil_lim  = cfg_q.sw4 ? SIL_SHORT_TK : SIL_LONG_TK;

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !out_lim)
      dly_q <= 12'h000;
    else if (tick_q && dly_q < ALARM_DELAY_TK)
      dly_q <= dly_q + 12'h001;
  end

  // A new trip wins over a clear in the same cycle.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      alarm_q <= 1'b0;
    else
      alarm_q <= trip || (alarm_q && !clr);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !alarm_q)
    begin
      sil_q      <= 12'h000;
      silenced_q <= 1'b0;
    end
    else
    begin
      if (tick_q && sil_q < sil_lim)
        sil_q <= sil_q + 12'h001;
      if (press.rst || (sil_en && sil_q >= sil_lim))
        silenced_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst || !mains_s)
      beep_q <= 1'b0;
    else if (press.rst)
      beep_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Display flashing
  // ----------------------------------------------------------------
  logic       phase_q;
  logic       save_flash_q;
  logic       lit_d;
  ctam_temp_t disp_d;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      phase_q      <= 1'b0;
      save_flash_q <= 1'b0;
    end
    else
    begin
      phase_q      <= phase_q ^ tick_q;
      save_flash_q <= commit || (save_flash_q && !tick_q);
    end
  end

  assign lit_d  = mains_s ? beep_q : !(save_flash_q || (alarm_q && phase_q));
  assign disp_d = (menu_q == MENU_UPPER)  ? upper_e_q :
                  (menu_q == MENU_LOWER)  ? lower_e_q :
                  (menu_q == MENU_PEAK)   ? peak_q :
                  (menu_q == MENU_TROUGH) ? trough_q :
                  (menu_q == MENU_CAL)    ? cal_e_q : temp_w;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_disp_value  <= '0;
      o_disp_lit    <= 1'b0;
      o_menu_item   <= 3'h0;
      o_batt_dots   <= 3'h0;
      o_alarm_relay <= 1'b0;
      o_audible     <= 1'b0;
    end
    else
    begin
      o_disp_value  <= disp_d;
      o_disp_lit    <= lit_d;
      o_menu_item   <= menu_q;
      o_batt_dots   <= {3{batt_s}};
      o_alarm_relay <= alarm_q;
      o_audible     <= (alarm_q && !silenced_q) || beep_q;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic        hit;
  logic [31:0] rd_word;

  assign hit     = (i_paddr == REG_STATUS) || (i_paddr == REG_TEMP) || (i_paddr == REG_LIMITS) ||
                   (i_paddr == REG_LOGS) || (i_paddr == REG_CAL);
  assign rd_word = (i_paddr == REG_STATUS) ? {25'h0, mains_s, batt_s, alarm_q, o_audible, menu_q} :
                   (i_paddr == REG_TEMP)   ? {22'h0, temp_w} :
                   (i_paddr == REG_LIMITS) ? {6'h0, upper_q, 6'h0, lower_q} :
                   (i_paddr == REG_LOGS)   ? {6'h0, peak_q, 6'h0, trough_q} :
                   (i_paddr == REG_CAL)    ? {22'h0, cal_q} : 32'h0;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= apb_acc && !o_pready;
      o_prdata  <= (apb_acc && !o_pready && !i_pwrite) ? rd_word : 32'h0;
      o_pslverr <= apb_acc && !o_pready && !hit;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_flash_dark;
    save_flash_q ##1 !o_disp_lit;
  endsequence

  a_menu_entry_order: assert property (
    menu_q == MENU_LOWER && press.set && !timeout |=> menu_q == MENU_PEAK ##0 o_menu_item == MENU_LOWER)
    else $error("menu did not step from lower to peak");
  a_limit_range: assert property (
    upper_q >= LIMIT_MIN && upper_q <= LIMIT_MAX && lower_q >= LIMIT_MIN && lower_q <= LIMIT_MAX)
    else $error("alarm limit out of range");
  a_peak_clear: assert property (
    log_ok_q && press.rst |=> peak_q == $past(temp_w))
    else $error("peak log not cleared by reset press");
  a_trough_order: assert property (
    log_ok_q |-> trough_q <= peak_q)
    else $error("trough above peak");
  a_cal_display: assert property (
    menu_q == MENU_IDLE |=> o_disp_value == $past(sens_s) + $past(cal_q))
    else $error("display not offset by calibration");
  a_timeout_discard: assert property (
    timeout |=> menu_q == MENU_IDLE && upper_q == $past(upper_q) && cal_q == $past(cal_q))
    else $error("timeout kept menu or stored edit");
  a_save_flash: assert property (
    commit |=> s_flash_dark)
    else $error("save did not flash display");
  a_store_only_commit: assert property (
    upper_q != $past(upper_q) |-> $past(commit))
    else $error("upper limit changed without save");
  a_delay_hold: assert property (
    $rose(alarm_q) && cfg_q.delay_en |-> $past(dly_q) >= ALARM_DELAY_TK)
    else $error("alarm before delay elapsed");
  a_auto_clear: assert property (
    alarm_q && cfg_ok && !cfg_q.manual_rst && !out_lim |=> !alarm_q ##1 !o_alarm_relay)
    else $error("automatic clear failed");
  a_manual_hold: assert property (
    alarm_q && cfg_q.manual_rst && !press.rst && !no_alarm |=> alarm_q)
    else $error("manual alarm dropped without reset press");
  a_no_alarm: assert property (
    cfg_ok && no_alarm |=> !alarm_q)
    else $error("alarm active while disabled");
  a_silence_press: assert property (
    alarm_q && press.rst && !mains_s && !beep_q |=> ##1 !o_audible)
    else $error("reset press did not silence audible");
  a_batt_dots: assert property (
    batt_s |=> o_batt_dots == 3'h7)
    else $error("battery dots not lit");

endmodule

// ===== verilog/ctam_pkg.sv
// Constants, types and register map for the cabinet thermometer alarm monitor.
// Assumes a 20 MHz system clock and a once-per-second enable derived from it.
package ctam_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          SEC_CYCLES      = CLK_HZ;
  localparam int          MENU_TIMEOUT_S  = 15;
  localparam int          ALARM_DELAY_MIN = 45;
  localparam int          SIL_SHORT_MIN   = 5;
  localparam int          SIL_LONG_MIN    = 45;
  localparam logic [11:0] MENU_TO_TK      = 12'(MENU_TIMEOUT_S);
  localparam logic [11:0] ALARM_DELAY_TK  = 12'(ALARM_DELAY_MIN * 60);
  localparam logic [11:0] SIL_SHORT_TK    = 12'(SIL_SHORT_MIN * 60);
  localparam logic [11:0] SIL_LONG_TK     = 12'(SIL_LONG_MIN * 60);
  localparam logic [1:0]  CFG_CAP_DONE    = 2'h3;

  // ----------------------------------------------------------------
  // Temperature values and ranges
  // ----------------------------------------------------------------
  typedef logic signed [9:0] ctam_temp_t;
  localparam ctam_temp_t LIMIT_MIN   = 10'h3D8;
  localparam ctam_temp_t LIMIT_MAX   = 10'h0C7;
  localparam ctam_temp_t CAL_MIN     = 10'h3E2;
  localparam ctam_temp_t CAL_MAX     = 10'h01E;
  localparam ctam_temp_t UPPER_RESET = 10'h0C7;
  localparam ctam_temp_t LOWER_RESET = 10'h3D8;
  localparam ctam_temp_t CAL_RESET   = 10'h000;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_TEMP   = 8'h04;
  localparam logic [7:0] REG_LIMITS = 8'h08;
  localparam logic [7:0] REG_LOGS   = 8'h0C;
  localparam logic [7:0] REG_CAL    = 8'h10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MENU_IDLE   = 3'b000,
    MENU_UPPER  = 3'b001,
    MENU_LOWER  = 3'b010,
    MENU_PEAK   = 3'b011,
    MENU_TROUGH = 3'b100,
    MENU_CAL    = 3'b101
  } ctam_menu_e;

  typedef struct packed {
    logic delay_en;
    logic manual_rst;
    logic sw3;
    logic sw4;
  } ctam_cfg_s;

  typedef struct packed {
    logic set;
    logic up;
    logic down;
    logic rst;
  } ctam_btn_s;

endpackage

// ===== dv/ctam_operator.sv
// Operator and sensor model: drives the four button pins and the sensor word.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps

module ctam_operator
  import ctam_pkg::*;
(
  // Clock
  input  wire logic i_clk,
  // Pins toward the monitor
  output ctam_btn_s  o_btn,
  output ctam_temp_t o_sensor
);
  initial
  begin
    o_btn    = '0;
    o_sensor = 10'h014;
  end

  // A press is held, then released, long enough to pass the pin synchroniser.
  task automatic press(input int b);
    @(posedge i_clk);
    o_btn[b] <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_btn[b] <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask

  // The sensor word stays steady for several cycles after each change.
  task automatic heat(input ctam_temp_t t);
    @(posedge i_clk);
    o_sensor <= t;
    repeat (8) @(posedge i_clk);
  endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for the cabinet thermometer alarm monitor.
// Assumes the operator model drives buttons and sensor; the bench drives APB and pins.
`timescale 1ns/1ps

module tb;
  import ctam_pkg::*;
  localparam int TK    = 20;
  localparam int B_SET = 3;
  localparam int B_UP  = 2;
  localparam int B_DN  = 1;
  localparam int B_RST = 0;

  logic        i_clk        = 1'b0;
  logic        i_rst;
  ctam_cfg_s   i_dip;
  logic        i_batt_low;
  logic        i_mains_lost;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] rd;
  logic        err;
  int          bad_count    = 0;
  int          comparisons  = 0;
  ctam_btn_s   btn;
  ctam_temp_t  sensor;
  ctam_temp_t  disp_value;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        disp_lit;
  logic [2:0]  menu_item;
  logic [2:0]  batt_dots;
  logic        relay;
  logic        audible;

  always #25 i_clk = ~i_clk;

  ctam_operator ctam_operator_inst (.i_clk(i_clk), .o_btn(btn), .o_sensor(sensor));

  ctam_monitor #(.P_SEC_CYCLES(TK)) ctam_monitor_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_btn(btn), .i_dip(i_dip), .i_batt_low(i_batt_low),
    .i_mains_lost(i_mains_lost), .i_sensor(sensor), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_disp_value(disp_value), .o_disp_lit(disp_lit),
    .o_menu_item(menu_item), .o_batt_dots(batt_dots), .o_alarm_relay(relay), .o_audible(audible));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One APB transfer; read data and error are taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1, pready);
  endtask

  task automatic do_reset(input ctam_cfg_s d);
    @(posedge i_clk);
    i_rst <= 1'b1;
    i_dip <= d;
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask

  task automatic step(input int b, input logic [2:0] m);
    ctam_operator_inst.press(b);
    chk("menu item", m, menu_item);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    apb(0, REG_LIMITS, 0);
    chk("limits", 32'h00C703D8, rd);
    apb(0, REG_CAL, 0);
    chk("cal", 0, rd);
    apb(0, 8'h14, 0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    apb(1, REG_CAL, 32'h5);
    apb(0, REG_TEMP, 0);
    chk("temp", 32'h19, rd);
    apb(1, REG_CAL, 32'h1F);
    apb(0, REG_CAL, 0);
    chk("cal bound", 32'h5, rd);
    apb(1, REG_CAL, 0);
    $display("test regs done");
  endtask

  task automatic t_menu();
    logic seen;
    seen = 1'b0;
    step(B_SET, 3'h1);
    chk("upper", 32'h0C7, disp_value);
    step(B_UP, 3'h1);
    chk("upper clamp", 32'h0C7, disp_value);
    step(B_DN, 3'h1);
    chk("upper edit", 32'h0C6, disp_value);
    step(B_SET, 3'h2);
    step(B_DN, 3'h2);
    chk("lower clamp", 32'hFFFFFFD8, disp_value);
    step(B_SET, 3'h3);
    step(B_SET, 3'h4);
    step(B_SET, 3'h5);
    step(B_UP, 3'h5);
    chk("cal edit", 32'h1, disp_value);
    chk("lit", 1, disp_lit);
    fork
      ctam_operator_inst.press(B_SET);
      repeat (14)
      begin
        @(posedge i_clk);
        if (disp_lit === 1'b0)
          seen = 1'b1;
      end
    join
    chk("save flash", 1, seen);
    chk("menu idle", 0, menu_item);
    apb(0, REG_LIMITS, 0);
    chk("limits saved", 32'h00C603D8, rd);
    apb(0, REG_CAL, 0);
    chk("cal saved", 1, rd);
    apb(1, REG_CAL, 0);
    $display("test menu done");
  endtask

  task automatic t_tmo();
    step(B_SET, 3'h1);
    step(B_DN, 3'h1);
    chk("edit", 32'h0C5, disp_value);
    repeat (14 * TK) @(posedge i_clk);
    chk("menu held", 1, menu_item);
    repeat (3 * TK) @(posedge i_clk);
    chk("menu timeout", 0, menu_item);
    apb(0, REG_LIMITS, 0);
    chk("limits kept", 32'h00C603D8, rd);
    $display("test timeout done");
  endtask

  task automatic t_auto();
    int   n;
    logic p;
    n = 0;
    ctam_operator_inst.heat(10'h0C7);
    chk("relay on", 1, relay);
    chk("audible on", 1, audible);
    p = disp_lit;
    repeat (3 * TK)
    begin
      @(posedge i_clk);
      if (disp_lit !== p)
        n++;
      p = disp_lit;
    end
    chk("flash toggles", 3, n);
    apb(0, REG_LOGS, 0);
    chk("logs", 32'h00C70014, rd);
    ctam_operator_inst.press(B_RST);
    chk("silenced", 0, audible);
    chk("relay held", 1, relay);
    apb(0, REG_LOGS, 0);
    chk("logs cleared", 32'h00C700C7, rd);
    ctam_operator_inst.heat(10'h014);
    chk("auto clear", 0, relay);
    ctam_operator_inst.heat(10'h3FB);
    apb(0, REG_LOGS, 0);
    chk("trough", 32'h00C703FB, rd);
    ctam_operator_inst.heat(10'h014);
    $display("test auto done");
  endtask

  task automatic t_pins();
    i_batt_low <= 1'b1;
    repeat (8) @(posedge i_clk);
    chk("dots on", 3'h7, batt_dots);
    i_batt_low <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk("dots off", 0, batt_dots);
    i_mains_lost <= 1'b1;
    ctam_operator_inst.press(B_RST);
    chk("outage sound", 1, audible);
    chk("outage lit", 1, disp_lit);
    chk("outage temp", 32'h014, disp_value);
    i_mains_lost <= 1'b0;
    repeat (8) @(posedge i_clk);
    $display("test pins done");
  endtask

  task automatic t_manual();
    do_reset(4'b0100);
    ctam_operator_inst.heat(10'h0C8);
    chk("relay on", 1, relay);
    ctam_operator_inst.heat(10'h014);
    repeat (4 * TK) @(posedge i_clk);
    chk("relay latched", 1, relay);
    chk("audible latched", 1, audible);
    ctam_operator_inst.press(B_RST);
    chk("manual clear", 0, relay);
    $display("test manual done");
  endtask

  task automatic t_quiet();
    do_reset(4'b0011);
    i_dip <= '0;
    ctam_operator_inst.heat(10'h0C8);
    repeat (2 * TK) @(posedge i_clk);
    chk("no relay", 0, relay);
    chk("no audible", 0, audible);
    ctam_operator_inst.heat(10'h014);
    $display("test quiet done");
  endtask

  task automatic t_silence();
    do_reset(4'b0001);
    ctam_operator_inst.heat(10'h0C8);
    chk("audible on", 1, audible);
    repeat (295 * TK) @(posedge i_clk);
    chk("audible early", 1, audible);
    repeat (10 * TK) @(posedge i_clk);
    chk("audible off", 0, audible);
    chk("relay stays", 1, relay);
    ctam_operator_inst.heat(10'h014);
    $display("test silence done");
  endtask

  // Switch one on: the alarm waits for the full delay of continuous excursion.
  task automatic t_delay();
    do_reset(4'b1000);
    ctam_operator_inst.heat(10'h0C8);
    repeat (2690 * TK) @(posedge i_clk);
    chk("delay early", 0, relay);
    repeat (20 * TK) @(posedge i_clk);
    chk("delay relay", 1, relay);
    chk("delay audible", 1, audible);
    ctam_operator_inst.heat(10'h014);
    chk("delay clear", 0, relay);
    $display("test delay done");
  endtask

  initial
  begin
    repeat (70000) @(posedge i_clk);
    bad_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    stop_test();
  end

  initial
  begin
    i_rst        = 1'b1;
    i_dip        = '0;
    i_batt_low   = 1'b0;
    i_mains_lost = 1'b0;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = '0;
    pwdata       = '0;
    do_reset('0);
    t_regs();
    t_menu();
    t_tmo();
    t_auto();
    t_pins();
    t_manual();
    t_quiet();
    t_silence();
    t_delay();
    stop_test();
  end
endmodule
